/* File: hw/tss_map_store.sv */
// Writable per-channel bitmap, one word per transmit row, read and written a byte at a time.
`timescale 1ns/1ns
module tss_map_store #(
  parameter int ROWS = 15,
  parameter int COLS = 10
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_idx,
  output logic [7:0] rd_data,
  output logic [ROWS*16-1:0] map_bits
);

  logic [COLS-1:0] map_reg [ROWS];
  logic [COLS-1:0] map_next [ROWS];
  logic [15:0] word;
  logic [15:0] rd_word;

  always_comb begin
    for (int r = 0; r < ROWS; r++) begin
      map_next[r] = map_reg[r];
      word = 16'h0000;
      word[COLS-1:0] = map_reg[r];
      if (wr_en && (wr_idx[7:1] == 7'(r))) begin
        if (wr_idx[0]) begin
          word[7:0] = wr_data;
        end else begin
          word[15:8] = wr_data;
        end
        map_next[r] = word[COLS-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int r = 0; r < ROWS; r++) begin
        map_reg[r] <= '0;
      end
    end else begin
      for (int r = 0; r < ROWS; r++) begin
        map_reg[r] <= map_next[r];
      end
    end
  end

  always_comb begin
    rd_word = 16'h0000;
    for (int r = 0; r < ROWS; r++) begin
      if (rd_idx[7:1] == 7'(r)) begin
        rd_word[COLS-1:0] = map_reg[r];
      end
    end
    rd_data = rd_idx[0] ? rd_word[7:0] : rd_word[15:8];
  end

  genvar g;
  generate
    for (g = 0; g < ROWS; g++) begin : g_out
      assign map_bits[g*16 +: 16] = {{(16-COLS){1'b0}}, map_reg[g]};
    end
  endgenerate

endmodule

/* File: hw/tss_pkg.sv */
// Shared constants and carrier types for the trackpad system status and control block.
package tss_pkg;

  localparam int ROWS = 15;
  localparam int COLS = 10;
  localparam int CHANNELS = 150;
  localparam int ADDR_W = 16;

  localparam logic [15:0] ADDR_STATUS_PRI = 16'h0000;
  localparam logic [15:0] ADDR_STATUS_SEC = 16'h0001;
  localparam logic [15:0] ADDR_COMMAND = 16'h0002;
  localparam logic [15:0] ADDR_PROX_MAP = 16'h0010;
  localparam logic [15:0] ADDR_TOUCH_MAP = 16'h0030;
  localparam logic [15:0] ADDR_SNAP_MAP = 16'h0050;
  localparam logic [15:0] ADDR_ACTIVE_MAP = 16'h0070;
  localparam logic [15:0] ADDR_SNAPEN_MAP = 16'h0090;
  localparam logic [15:0] ADDR_COUNT = 16'h0100;
  localparam logic [15:0] ADDR_DELTA = 16'h0300;
  localparam logic [15:0] ADDR_REFERENCE = 16'h0500;

  localparam logic [15:0] MAP_BYTES = 16'h001E;
  localparam logic [15:0] PROX_MAP_BYTES = 16'h0020;
  localparam logic [15:0] VALUE_BYTES = 16'h012C;

  localparam int PRI_RESET_SEEN = 7;
  localparam int PRI_AUX_RETUNE = 6;
  localparam int PRI_AUX_ERROR = 5;
  localparam int PRI_PAD_RETUNE = 4;
  localparam int PRI_PAD_ERROR = 3;

  localparam int SEC_SWITCH = 5;
  localparam int SEC_SNAP_CHANGE = 4;
  localparam int SEC_RR_MISS = 3;
  localparam int SEC_FINGERS = 2;
  localparam int SEC_PALM = 1;
  localparam int SEC_MOTION = 0;

  localparam int CMD_ACK_RESET = 7;
  localparam int CMD_RUN_TUNING = 5;
  localparam int CMD_AUX_RESEED = 4;
  localparam int CMD_PAD_RESEED = 3;

  localparam logic [2:0] MODE_ACTIVE = 3'h0;
  localparam logic [2:0] MODE_IDLE_TOUCH = 3'h1;
  localparam logic [2:0] MODE_IDLE = 3'h2;
  localparam logic [2:0] MODE_LOW_POWER_ONE = 3'h3;
  localparam logic [2:0] MODE_LOW_POWER_TWO = 3'h4;

  localparam logic RESET_SEEN_INIT = 1'b1;
  localparam logic [2:0] MODE_SELECT_INIT = 3'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef logic [2:0] tss_mode_t;

  typedef struct packed {
    logic pad_retune_done;
    logic aux_channel_retune_done;
    logic pad_tune_end;
    logic pad_tune_fail;
    logic aux_tune_end;
    logic aux_tune_fail;
    logic snap_change;
    logic report_rate_miss;
    logic finger_overflow;
    logic palm_detect;
    logic pad_motion_flag;
  } tss_sense_s;

  typedef struct packed {
    logic run_tuning_cmd;
    logic aux_average_reseed_cmd;
    logic pad_reseed_cmd;
  } tss_cmd_s;

endpackage

/* File: hw/tss_regs.sv */
// System status, command and channel data register bank of the trackpad controller.
// Summary of operation
// R1: Any reset sets the reset-seen flag, bit 7 of primary status, until acknowledged.
// R2: Writing one to command bit 7 clears reset-seen; zero does nothing.
// R3: Primary bit 6 shows a just-completed auxiliary channel retune.
// R4: Primary bit 5 shows errors in the latest auxiliary channel tuning run.
// R5: Primary bit 4 shows a just-completed trackpad retune.
// R6: Primary bit 3 shows errors in the latest trackpad tuning run.
// R7: Primary bits 2:0 show the current power mode, 000 active to 100 second low-power.
// R8: Secondary bit 5 mirrors the switch input pin level.
// R9: Secondary bit 4 shows that some channel changed snap status.
// R10: Secondary bit 3 shows that the report rate was missed.
// R11: Secondary bit 2 shows more fingers than the configured maximum.
// R12: Secondary bit 1 shows a detected palm.
// R13: Secondary bit 0 shows finger movement on the pad.
// R14: Bitmaps hold one word per transmit row, high byte first, bits 9:0 receive columns.
// R15: Bitmap layout never changes with axis swap: bit is receive, word is transmit.
// R16: Proximity bitmap carries two extra bytes; auxiliary channel proximity in bit 0.
// R17: A one in a bitmap means present, enabled or snap enabled.
// R18: Count, delta and reference arrays: two bytes per channel, high first, transmit-major.
// R19: Writing one to command bit 5 starts tuning for the current mode's channels.
// R20: Writing one to command bit 4 reseeds the auxiliary channel long-term average.
// R21: Writing one to command bit 3 reseeds all trackpad references.
// R22: Command bits 2:0 select the power mode, effective only under manual control.
// R23: Manual control set lets the host choose modes; clear lets the device choose.
// R24: Command action bits act once per written one and read back as zero; bits 2:0 read back the mode select.
`timescale 1ns/1ns
module tss_regs #(
  parameter int ROWS = 15,
  parameter int COLS = 10,
  parameter int CHANNELS = 150
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire tss_pkg::tss_sense_s sense,
  input wire tss_pkg::tss_mode_t power_mode,
  input wire logic switch_input_pin,
  input wire logic manual_control,
  input wire logic [ROWS*16-1:0] prox_map,
  input wire logic [ROWS*16-1:0] touch_map,
  input wire logic [ROWS*16-1:0] snap_map,
  input wire logic aux_prox,
  input wire logic val_wr,
  input wire logic [1:0] val_kind,
  input wire logic [7:0] val_chan,
  input wire logic [15:0] val_data,
  output tss_pkg::tss_cmd_s cmd,
  output tss_pkg::tss_mode_t mode_select,
  output logic mode_override,
  output logic [ROWS*16-1:0] active_map_bits,
  output logic [ROWS*16-1:0] snap_enable_map_bits
);

  function automatic logic in_window(input logic [15:0] addr, input logic [15:0] base, input logic [15:0] len);
    in_window = (addr >= base) && (addr < (base + len));
  endfunction

  function automatic logic [7:0] map_byte(input logic [ROWS*16-1:0] bits, input logic [15:0] idx);
    logic [15:0] word;
    word = 16'h0000;
    for (int r = 0; r < ROWS; r++) begin
      if (idx[7:1] == 7'(r)) begin
        word = bits[r*16 +: 16];
      end
    end
    word[15:COLS] = '0;
    map_byte = idx[0] ? word[7:0] : word[15:8];
  endfunction

  logic reset_seen_reg, reset_seen_next;
  logic aux_retune_reg, aux_retune_next;
  logic aux_error_reg, aux_error_next;
  logic pad_retune_reg, pad_retune_next;
  logic pad_error_reg, pad_error_next;
  tss_pkg::tss_mode_t mode_reg, mode_next;
  logic [5:0] sec_reg, sec_next;
  tss_pkg::tss_cmd_s cmd_reg, cmd_next;
  tss_pkg::tss_mode_t mode_sel_reg, mode_sel_next;
  logic override_reg, override_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  logic wr_cmd;
  logic rd_pri;
  logic [15:0] off_active, off_snapen, off_count, off_delta, off_ref;
  logic [7:0] active_rd, snapen_rd;
  logic [7:0] value_rd [3];
  logic [15:0] value_base [3];
  logic wr_active, wr_snapen;

  assign wr_cmd = reg_wr && (reg_addr == tss_pkg::ADDR_COMMAND);
  assign rd_pri = reg_rd && (reg_addr == tss_pkg::ADDR_STATUS_PRI);
  assign off_active = reg_addr - tss_pkg::ADDR_ACTIVE_MAP;
  assign off_snapen = reg_addr - tss_pkg::ADDR_SNAPEN_MAP;
  assign off_count = reg_addr - tss_pkg::ADDR_COUNT;
  assign off_delta = reg_addr - tss_pkg::ADDR_DELTA;
  assign off_ref = reg_addr - tss_pkg::ADDR_REFERENCE;
  assign wr_active = reg_wr && in_window(reg_addr, tss_pkg::ADDR_ACTIVE_MAP, tss_pkg::MAP_BYTES);
  assign wr_snapen = reg_wr && in_window(reg_addr, tss_pkg::ADDR_SNAPEN_MAP, tss_pkg::MAP_BYTES);
  assign value_base[0] = tss_pkg::ADDR_COUNT;
  assign value_base[1] = tss_pkg::ADDR_DELTA;
  assign value_base[2] = tss_pkg::ADDR_REFERENCE;

  // Host-writable bitmaps; a one enables the channel or its snap feature.
  tss_map_store #(.ROWS(ROWS), .COLS(COLS)) u_active_map ( // R17
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wr_en(wr_active),
    .wr_idx(off_active[7:0]),
    .wr_data(reg_wdata),
    .rd_idx(off_active[7:0]),
    .rd_data(active_rd),
    .map_bits(active_map_bits)
  );

  tss_map_store #(.ROWS(ROWS), .COLS(COLS)) u_snapen_map (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wr_en(wr_snapen),
    .wr_idx(off_snapen[7:0]),
    .wr_data(reg_wdata),
    .rd_idx(off_snapen[7:0]),
    .rd_data(snapen_rd),
    .map_bits(snap_enable_map_bits)
  );

  // Channel data arrays, one per kind, linear index is transmit row times columns plus receive.
  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_values
      logic [15:0] off;
      assign off = reg_addr - value_base[k];
      tss_value_store #(.CHANNELS(CHANNELS)) u_values ( // R18
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .wr_en(val_wr && (val_kind == 2'(k))),
        .wr_chan(val_chan),
        .wr_data(val_data),
        .rd_idx(off[8:0]),
        .rd_data(value_rd[k])
      );
    end
  endgenerate

  // Primary status flags.
  always_comb begin
    reset_seen_next = reset_seen_reg;
    if (wr_cmd && reg_wdata[tss_pkg::CMD_ACK_RESET]) begin
      reset_seen_next = 1'b0; // R2
    end
    aux_retune_next = aux_retune_reg;
    if (rd_pri) begin
      aux_retune_next = 1'b0;
    end
    if (sense.aux_channel_retune_done) begin
      aux_retune_next = 1'b1; // R3
    end
    pad_retune_next = pad_retune_reg;
    if (rd_pri) begin
      pad_retune_next = 1'b0;
    end
    if (sense.pad_retune_done) begin
      pad_retune_next = 1'b1; // R5
    end
    aux_error_next = aux_error_reg;
    if (sense.aux_tune_end) begin
      aux_error_next = sense.aux_tune_fail; // R4
    end
    pad_error_next = pad_error_reg;
    if (sense.pad_tune_end) begin
      pad_error_next = sense.pad_tune_fail; // R6
    end
    mode_next = power_mode; // R7
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_seen_reg <= tss_pkg::RESET_SEEN_INIT; // R1
      aux_retune_reg <= 1'b0;
      aux_error_reg <= 1'b0;
      pad_retune_reg <= 1'b0;
      pad_error_reg <= 1'b0;
      mode_reg <= tss_pkg::MODE_ACTIVE;
    end else begin
      reset_seen_reg <= reset_seen_next;
      aux_retune_reg <= aux_retune_next;
      aux_error_reg <= aux_error_next;
      pad_retune_reg <= pad_retune_next;
      pad_error_reg <= pad_error_next;
      mode_reg <= mode_next;
    end
  end

  // Secondary status bits follow their sources with one register stage.
  always_comb begin
    sec_next = 6'h00;
    sec_next[tss_pkg::SEC_SWITCH] = switch_input_pin; // R8
    sec_next[tss_pkg::SEC_SNAP_CHANGE] = sense.snap_change; // R9
    sec_next[tss_pkg::SEC_RR_MISS] = sense.report_rate_miss; // R10
    sec_next[tss_pkg::SEC_FINGERS] = sense.finger_overflow; // R11
    sec_next[tss_pkg::SEC_PALM] = sense.palm_detect; // R12
    sec_next[tss_pkg::SEC_MOTION] = sense.pad_motion_flag; // R13
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_reg <= 6'h00;
    end else begin
      sec_reg <= sec_next;
    end
  end

  // Command byte: action bits become single-cycle pulses, mode select is held.
  always_comb begin
    cmd_next = '0;
    mode_sel_next = mode_sel_reg;
    if (wr_cmd) begin
      cmd_next.run_tuning_cmd = reg_wdata[tss_pkg::CMD_RUN_TUNING]; // R19 R24
      cmd_next.aux_average_reseed_cmd = reg_wdata[tss_pkg::CMD_AUX_RESEED]; // R20
      cmd_next.pad_reseed_cmd = reg_wdata[tss_pkg::CMD_PAD_RESEED]; // R21
      mode_sel_next = reg_wdata[2:0]; // R22
    end
    override_next = manual_control; // R23
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_reg <= '0;
      mode_sel_reg <= tss_pkg::MODE_SELECT_INIT;
      override_reg <= 1'b0;
    end else begin
      cmd_reg <= cmd_next;
      mode_sel_reg <= mode_sel_next;
      override_reg <= override_next;
    end
  end

  // Read path: one registered byte per read strobe, unmapped addresses read zero.
  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = reg_rd;
    if (reg_rd) begin
      rdata_next = tss_pkg::BYTE_ZERO;
      if (reg_addr == tss_pkg::ADDR_STATUS_PRI) begin
        rdata_next = {reset_seen_reg, aux_retune_reg, aux_error_reg, pad_retune_reg, pad_error_reg, mode_reg};
      end else if (reg_addr == tss_pkg::ADDR_STATUS_SEC) begin
        rdata_next = {2'b00, sec_reg};
      end else if (reg_addr == tss_pkg::ADDR_COMMAND) begin
        rdata_next = {5'h00, mode_sel_reg}; // R24
      end else if (in_window(reg_addr, tss_pkg::ADDR_PROX_MAP, tss_pkg::PROX_MAP_BYTES)) begin
        if (reg_addr - tss_pkg::ADDR_PROX_MAP == tss_pkg::MAP_BYTES + 16'h0001) begin
          rdata_next = {7'h00, aux_prox}; // R16
        end else if (reg_addr - tss_pkg::ADDR_PROX_MAP < tss_pkg::MAP_BYTES) begin
          rdata_next = map_byte(prox_map, reg_addr - tss_pkg::ADDR_PROX_MAP); // R14 R15
        end
      end else if (in_window(reg_addr, tss_pkg::ADDR_TOUCH_MAP, tss_pkg::MAP_BYTES)) begin
        rdata_next = map_byte(touch_map, reg_addr - tss_pkg::ADDR_TOUCH_MAP); // R14
      end else if (in_window(reg_addr, tss_pkg::ADDR_SNAP_MAP, tss_pkg::MAP_BYTES)) begin
        rdata_next = map_byte(snap_map, reg_addr - tss_pkg::ADDR_SNAP_MAP); // R17
      end else if (in_window(reg_addr, tss_pkg::ADDR_ACTIVE_MAP, tss_pkg::MAP_BYTES)) begin
        rdata_next = active_rd;
      end else if (in_window(reg_addr, tss_pkg::ADDR_SNAPEN_MAP, tss_pkg::MAP_BYTES)) begin
        rdata_next = snapen_rd;
      end else if (in_window(reg_addr, tss_pkg::ADDR_COUNT, tss_pkg::VALUE_BYTES)) begin
        rdata_next = value_rd[0]; // R18
      end else if (in_window(reg_addr, tss_pkg::ADDR_DELTA, tss_pkg::VALUE_BYTES)) begin
        rdata_next = value_rd[1];
      end else if (in_window(reg_addr, tss_pkg::ADDR_REFERENCE, tss_pkg::VALUE_BYTES)) begin
        rdata_next = value_rd[2];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= tss_pkg::BYTE_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign cmd = cmd_reg;
  assign mode_select = mode_sel_reg;
  assign mode_override = override_reg;

  // Unused offsets of the count, delta and reference windows are intentionally ignored.
  logic unused_ok;
  assign unused_ok = ^{off_count, off_delta, off_ref};

endmodule

/* File: hw/tss_value_store.sv */
// Count, delta or reference array of one word per channel, read back high byte first.
`timescale 1ns/1ns
module tss_value_store #(
  parameter int CHANNELS = 150
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_chan,
  input wire logic [15:0] wr_data,
  input wire logic [8:0] rd_idx,
  output logic [7:0] rd_data
);

  logic [15:0] val_reg [CHANNELS];
  logic [15:0] val_next [CHANNELS];
  logic [15:0] rd_word;

  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      val_next[c] = val_reg[c];
      if (wr_en && (wr_chan == 8'(c))) begin
        val_next[c] = wr_data;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int c = 0; c < CHANNELS; c++) begin
        val_reg[c] <= 16'h0000;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        val_reg[c] <= val_next[c];
      end
    end
  end

  always_comb begin
    rd_word = 16'h0000;
    for (int c = 0; c < CHANNELS; c++) begin
      if (rd_idx[8:1] == 8'(c)) begin
        rd_word = val_reg[c];
      end
    end
    rd_data = rd_idx[0] ? rd_word[7:0] : rd_word[15:8];
  end

endmodule

/* File: tb/touch_system_status_control_test.sv */
// Self-checking bench for the trackpad system status and control register bank.
`timescale 1ns/1ns
module touch_system_status_control_test;
  logic sys_clk;
  logic arst_n;
  logic [15:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  tss_pkg::tss_sense_s sense;
  tss_pkg::tss_mode_t power_mode;
  logic switch_input_pin;
  logic manual_control;
  logic [239:0] prox_map;
  logic [239:0] touch_map;
  logic [239:0] snap_map;
  logic aux_prox;
  logic val_wr;
  logic [1:0] val_kind;
  logic [7:0] val_chan;
  logic [15:0] val_data;
  tss_pkg::tss_cmd_s cmd;
  tss_pkg::tss_mode_t mode_select;
  logic mode_override;
  logic [239:0] active_map_bits;
  logic [239:0] snap_enable_map_bits;
  int failures;
  int n_tests;
  logic [7:0] rb;
  logic ok;
  logic [10:0] ev [5] = '{11'h400, 11'h200, 11'h180, 11'h060, 11'h140};
  logic [7:0] ex1 [5] = '{8'h10, 8'h40, 8'h08, 8'h28, 8'h00};
  logic [7:0] ex2 [5] = '{8'h00, 8'h00, 8'h08, 8'h28, 8'h00};
  logic [15:0] map_a [8] = '{16'h0010, 16'h0011, 16'h002C, 16'h002D, 16'h002E, 16'h002F, 16'h0032, 16'h0055};
  logic [7:0] map_e [8] = '{8'h02, 8'h01, 8'h01, 8'h55, 8'h00, 8'h01, 8'h03, 8'h80};
  logic [15:0] vbase [3] = '{tss_pkg::ADDR_COUNT, tss_pkg::ADDR_DELTA, tss_pkg::ADDR_REFERENCE};

  tss_regs u_tss_regs (.sys_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
    .sense, .power_mode, .switch_input_pin, .manual_control, .prox_map, .touch_map, .snap_map, .aux_prox,
    .val_wr, .val_kind, .val_chan, .val_data, .cmd, .mode_select, .mode_override, .active_map_bits,
    .snap_enable_map_bits);
  tss_host_model u_tss_host_model (.sys_clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #2;
    end
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    u_tss_host_model.rd(a, rb, ok);
    chk({7'h00, ok}, 8'h01);
    chk(rb, exp);
  endtask
  task automatic reset_dut(input int n);
    arst_n = 1'b0;
    tick(n);
    arst_n = 1'b1;
    tick(1);
  endtask
  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    failures++;
    $display("BAD t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
    final_report;
  end

  initial begin
    failures = 0;
    n_tests = 0;
    arst_n = 1'b0;
    sense = '0;
    power_mode = tss_pkg::MODE_ACTIVE;
    switch_input_pin = 1'b0;
    manual_control = 1'b0;
    prox_map = '0;
    touch_map = '0;
    snap_map = '0;
    aux_prox = 1'b0;
    val_wr = 1'b0;
    val_kind = 2'h0;
    val_chan = 8'h00;
    val_data = 16'h0000;
    reset_dut(6);
    rchk(tss_pkg::ADDR_STATUS_PRI, 8'h80);
    rchk(16'h0003, 8'h00);
    u_tss_host_model.wr(tss_pkg::ADDR_STATUS_PRI, 8'h7F);
    u_tss_host_model.wr(tss_pkg::ADDR_COMMAND, 8'h00);
    rchk(tss_pkg::ADDR_STATUS_PRI, 8'h80);
    for (int m = 0; m < 5; m++) begin
      power_mode = 3'(m);
      tick(1);
      rchk(tss_pkg::ADDR_STATUS_PRI, 8'h80 | 8'(m));
    end
    power_mode = tss_pkg::MODE_ACTIVE;
    u_tss_host_model.wr(tss_pkg::ADDR_COMMAND, 8'h80);
    rchk(tss_pkg::ADDR_STATUS_PRI, 8'h00);
    $display("reset and mode test done");
    for (int i = 0; i < 5; i++) begin
      sense = tss_pkg::tss_sense_s'(ev[i]);
      tick(1);
      sense = '0;
      rchk(tss_pkg::ADDR_STATUS_PRI, ex1[i]);
      rchk(tss_pkg::ADDR_STATUS_PRI, ex2[i]);
    end
    for (int b = 0; b < 5; b++) begin
      sense = tss_pkg::tss_sense_s'(11'h001 << b);
      tick(1);
      rchk(tss_pkg::ADDR_STATUS_SEC, 8'h01 << b);
    end
    sense = '0;
    switch_input_pin = 1'b1;
    tick(1);
    rchk(tss_pkg::ADDR_STATUS_SEC, 8'h20);
    $display("status test done");
    manual_control = 1'b1;
    for (int m = 0; m < 5; m++) begin
      u_tss_host_model.wr(tss_pkg::ADDR_COMMAND, 8'h38 | 8'(m));
      chk({5'h00, mode_select}, 8'(m));
      chk({5'h00, cmd}, 8'h00);
      rchk(tss_pkg::ADDR_COMMAND, 8'(m));
    end
    u_tss_host_model.wr(tss_pkg::ADDR_COMMAND, 8'h04);
    chk({7'h00, mode_override}, 8'h01);
    $display("command test done");
    prox_map[15:0] = 16'h0201;
    prox_map[239:224] = 16'h0155;
    aux_prox = 1'b1;
    touch_map[31:16] = 16'hFF00;
    snap_map[47:32] = 16'h0280;
    tick(1);
    for (int i = 0; i < 8; i++) begin
      rchk(map_a[i], map_e[i]);
    end
    u_tss_host_model.wr(16'h0070, 8'hFF);
    u_tss_host_model.wr(16'h0071, 8'hFF);
    u_tss_host_model.wr(16'h0092, 8'h01);
    u_tss_host_model.wr(16'h0093, 8'h80);
    chk16(active_map_bits[15:0], 16'h03FF);
    chk16(snap_enable_map_bits[31:16], 16'h0180);
    rchk(16'h0070, 8'h03);
    rchk(16'h0093, 8'h80);
    $display("map test done");
    for (int k = 0; k < 3; k++) begin
      val_wr = 1'b1;
      val_kind = 2'(k);
      val_chan = 8'd149;
      val_data = 16'hC3A0 ^ 16'(k);
      tick(1);
      val_chan = 8'd10;
      val_data = 16'h5A0F;
      tick(1);
      val_wr = 1'b0;
      rchk(vbase[k] + 16'd298, 8'hC3);
      rchk(vbase[k] + 16'd299, 8'hA0 ^ 8'(k));
      rchk(vbase[k] + 16'd20, 8'h5A);
      rchk(vbase[k] + 16'd21, 8'h0F);
    end
    $display("value test done");
    reset_dut(2);
    rchk(tss_pkg::ADDR_STATUS_PRI, 8'h80);
    chk({5'h00, mode_select}, 8'h00);
    chk16(active_map_bits[15:0], 16'h0000);
    $display("second reset test done");
    final_report;
  end
endmodule

/* File: tb/tss_host_model.sv */
// Host model that issues byte reads and writes on the register port.
`timescale 1ns/1ns
module tss_host_model (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [15:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 16'hFFFF;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'hFF;
  end
  // Writes one byte; released lines show the inverse of the last value.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #2;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    @(posedge sys_clk);
    #2;
  endtask
  // Reads one byte; the answer stands in the cycle after the strobe.
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #2;
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = reg_rvalid;
    d = reg_rdata;
    @(posedge sys_clk);
    #2;
  endtask
endmodule

/* File: tb/tss_regs_props.sv */
// Concurrent checks on the ports of the register bank.
`timescale 1ns/1ns
module tss_regs_props (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire tss_pkg::tss_sense_s sense,
  input wire tss_pkg::tss_mode_t power_mode,
  input wire logic switch_input_pin,
  input wire logic manual_control,
  input wire tss_pkg::tss_cmd_s cmd,
  input wire tss_pkg::tss_mode_t mode_select,
  input wire logic mode_override
);
  logic wr_cmd;
  logic rd_pri;
  logic rd_sec;
  logic acked_reg;
  logic acked_next;
  assign wr_cmd = reg_wr && reg_addr == tss_pkg::ADDR_COMMAND;
  assign rd_pri = reg_rd && reg_addr == tss_pkg::ADDR_STATUS_PRI;
  assign rd_sec = reg_rd && reg_addr == tss_pkg::ADDR_STATUS_SEC;
  always_comb acked_next = acked_reg || (wr_cmd && reg_wdata[7]);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      acked_reg <= 1'b0;
    end else begin
      acked_reg <= acked_next;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_rvalid; reg_rd |=> reg_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read without answer");
  property p_rv_only; !reg_rd |=> !reg_rvalid; endproperty
  a_rv_only: assert property (p_rv_only) else $error("answer without read");
  property p_seen; rd_pri && !acked_reg |=> reg_rdata[7]; endproperty
  a_seen: assert property (p_seen) else $error("reset flag lost");
  property p_ack; wr_cmd && reg_wdata[7] ##2 rd_pri |=> !reg_rdata[7]; endproperty
  a_ack: assert property (p_ack) else $error("reset flag not cleared");
  property p_aux_rt; sense.aux_channel_retune_done ##1 rd_pri |=> reg_rdata[6]; endproperty
  a_aux_rt: assert property (p_aux_rt) else $error("aux retune not shown");
  property p_pad_rt; sense.pad_retune_done ##1 rd_pri |=> reg_rdata[4]; endproperty
  a_pad_rt: assert property (p_pad_rt) else $error("pad retune not shown");
  property p_err; sense.pad_tune_end ##1 rd_pri |=> reg_rdata[3] == $past(sense.pad_tune_fail, 2); endproperty
  a_err: assert property (p_err) else $error("pad tune error wrong");
  property p_mode; rd_pri && $stable(power_mode) && $past(arst_n) |=> reg_rdata[2:0] == $past(power_mode); endproperty
  a_mode: assert property (p_mode) else $error("mode field wrong");
  property p_sec;
    rd_sec && $stable(sense[4:0]) && $stable(switch_input_pin) && $past(arst_n)
    |=> reg_rdata == {2'b00, $past(switch_input_pin), $past(sense[4:0])};
  endproperty
  a_sec: assert property (p_sec) else $error("secondary status wrong");
  property p_tune; wr_cmd && reg_wdata[5] |=> cmd.run_tuning_cmd; endproperty
  a_tune: assert property (p_tune) else $error("tuning not started");
  property p_once; !(wr_cmd && reg_wdata[5]) |=> !cmd.run_tuning_cmd; endproperty
  a_once: assert property (p_once) else $error("tuning pulse unasked");
  property p_aux_rs; wr_cmd |=> cmd.aux_average_reseed_cmd == $past(reg_wdata[4]); endproperty
  a_aux_rs: assert property (p_aux_rs) else $error("aux reseed wrong");
  property p_pad_rs; wr_cmd |=> cmd.pad_reseed_cmd == $past(reg_wdata[3]); endproperty
  a_pad_rs: assert property (p_pad_rs) else $error("pad reseed wrong");
  property p_msel; wr_cmd |=> mode_select == $past(reg_wdata[2:0]); endproperty
  a_msel: assert property (p_msel) else $error("mode select wrong");
  property p_ovr; $past(arst_n) |-> mode_override == $past(manual_control); endproperty
  a_ovr: assert property (p_ovr) else $error("override wrong");
  c_tune: cover property (cmd.run_tuning_cmd);
  c_seen: cover property (reg_rvalid && reg_rdata[7]);
  c_ovr: cover property (mode_override);
endmodule
bind tss_regs tss_regs_props u_tss_regs_props (.sys_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata, .reg_rvalid, .sense, .power_mode, .switch_input_pin, .manual_control, .cmd, .mode_select,
  .mode_override);
